// File: core/acr_pkg.sv
// Package with register map, field layout and carrier types of the codec config bank
package acr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CONV_PORT = 16'h1056;
    localparam logic [15:0] IDX_ADC_SEL = 16'h1057;
    localparam logic [15:0] IDX_POWER = 16'h1058;
    localparam logic [15:0] IDX_USER2 = 16'h105a;
    localparam logic [15:0] IDX_CLK_STAT = 16'h1060;
    localparam logic [15:0] IDX_DAC_AMP = 16'h1061;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h1062;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h1063;
    localparam int ADDR_W = 16;

    // Converter port register fields
    localparam int CP_SEL_LSB = 5;
    localparam int CP_LR_POL = 4;
    localparam int CP_BCLK_POL = 3;
    localparam int CP_FMT_LSB = 0;
    localparam logic [6:0] CP_MASK = 7'h7f;
    localparam logic [7:0] CONV_PORT_RST = 8'h00;
    // Format codes
    localparam logic [2:0] FMT_I2S = 3'h0;
    localparam logic [2:0] FMT_LJ = 3'h1;
    localparam logic [2:0] FMT_RJ24 = 3'h3;
    localparam logic [2:0] FMT_RJ20 = 3'h4;
    localparam logic [2:0] FMT_RJ18 = 3'h5;
    localparam logic [2:0] FMT_RJ16 = 3'h6;

    // Input mux, power and user control two
    localparam logic [3:0] ADC_SEL_RST = 4'h1;
    localparam logic [15:0] POWER_RST = 16'h0000;
    localparam int PWR_PLL = 15;
    localparam int PWR_SRC = 2;
    localparam int PWR_ENGINE = 1;
    localparam int PWR_DSP = 0;
    localparam int U2_MUTE = 7;
    localparam int U2_ATT_W = 5;
    localparam logic [7:0] USER2_RST = 8'h00;

    // Clock and converter status register fields
    localparam int CS_ONES_LSB = 9;
    localparam logic [3:0] CS_ONES = 4'hf;
    localparam int CS_MUX_EN = 8;
    localparam int CS_LOCK = 7;
    localparam int CS_MCLK_EN = 6;
    localparam int CS_MSEL_LSB = 3;
    localparam int CS_PSEL_LSB = 1;
    localparam int CS_PLL_EN = 0;
    localparam logic [2:0] MSEL_X1024 = 3'h1;
    localparam logic [8:0] CLK_STAT_RST = 9'h000;

    // DAC amplifier register
    localparam int DA_CHOP_DIS = 1;
    localparam logic DAC_AMP_RST = 1'b0;

    // Interrupt bits: lock gained, lock lost
    localparam int IRQ_W = 2;
    localparam int IRQ_LOCK_ON = 0;
    localparam int IRQ_LOCK_OFF = 1;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    // Converter serial input settings
    typedef struct packed {
        logic [3:0] port_onehot;  // Bit n routes serial input n
        logic left_high;
        logic data_rising;
        logic fmt_i2s;
        logic fmt_left_just;
        logic fmt_right_just;
        logic [4:0] rj_bits;
        logic fmt_valid;
    } acr_src_cfg_t;

    // Clock generation settings
    typedef struct packed {
        logic src_mux_en;
        logic mclk_x1024;
        logic mclk_x128;
        logic [3:0] pll_ratio_onehot;  // 64,128,256,512 x fs
        logic pll_in_use;
    } acr_clk_cfg_t;
endpackage

// File: core/acr_sync3.sv
// Three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ns
module acr_sync3 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Shift chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept level only when the last two stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else if (s2_r == s3_r) begin
            q <= s3_r;
        end
    end
endmodule

// File: core/acr_irq.sv
// Sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ns
module acr_irq #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] event_in,
    input wire logic [W-1:0] clear,
    input wire logic [W-1:0] mask,
    output logic [W-1:0] status,
    output logic irq
);
    // Per-bit sticky flag, a new event beats a clear
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                status[i] <= 1'b0;
            end else if (event_in[i]) begin
                status[i] <= 1'b1;
            end else if (clear[i]) begin
                status[i] <= 1'b0;
            end
        end
    end

    // Registered interrupt level, a set mask bit keeps its flag off the line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |((status | event_in) & ~clear & ~mask) | |(event_in & ~mask);
        end
    end
endmodule

// File: core/acr_regs.sv
// Configuration and status register bank of the codec, reached over APB
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
// Function
// - Port select 00..11 routes serial input three, two, one, zero.
// - Frame polarity 0 takes left on low frame clock; 1 swaps halves.
// - Bit clock polarity 0 means data changes on falling edge; 1 rising.
// - Format 000 I2S, 001 left, 011..110 right 24/20/18/16; others reserved.
// - Input mux bits 0..3 connect analog inputs one..four; reset selects one.
// - Power bits: 1 powers block up; all reset to zero.
// - Bit 7 mutes headphone; bits 4:0 attenuate in 1.5 dB steps.
// - Status bits 12:9 always read back as ones.
// - Bit 8 enables converter mux; bit 7 read-only lock indicator.
// - Bit 6 enables the master clock output pin.
// - Clock select 001 gives 1024 fs, 1xx gives 128 fs.
// - PLL select gives 64..512 fs; bit 0 uses PLL when 1.
// - Chopping bit 0 enables chopping, 1 disables it.
module acr_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic src_locked_pin,
    output acr_pkg::acr_src_cfg_t src_cfg,
    output logic analog_input_one_en,
    output logic analog_input_two_en,
    output logic analog_input_three_en,
    output logic analog_input_four_en,
    output logic [15:0] power_up,
    output logic hp_mute,
    output logic [4:0] hp_atten_steps,
    output logic master_clock_out_pin_en,
    output acr_pkg::acr_clk_cfg_t clk_cfg,
    output logic dac_chop_en,
    output logic irq
);
    // Byte addresses
    localparam logic [15:0] A_CONV = 16'(acr_pkg::IDX_CONV_PORT * 4);
    localparam logic [15:0] A_ADC = 16'(acr_pkg::IDX_ADC_SEL * 4);
    localparam logic [15:0] A_PWR = 16'(acr_pkg::IDX_POWER * 4);
    localparam logic [15:0] A_U2 = 16'(acr_pkg::IDX_USER2 * 4);
    localparam logic [15:0] A_CS = 16'(acr_pkg::IDX_CLK_STAT * 4);
    localparam logic [15:0] A_DA = 16'(acr_pkg::IDX_DAC_AMP * 4);
    localparam logic [15:0] A_IST = 16'(acr_pkg::IDX_IRQ_STAT * 4);
    localparam logic [15:0] A_IMK = 16'(acr_pkg::IDX_IRQ_MASK * 4);

    logic [6:0] conv_port_r;
    logic [3:0] adc_sel_r;
    logic [15:0] power_r;
    logic hp_mute_r;
    logic [4:0] hp_att_r;
    logic [8:0] clk_stat_r;
    logic dac_chop_dis_r;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_status;
    logic [1:0] irq_clear;
    logic [1:0] irq_event;
    logic locked;
    logic locked_d_r;
    logic access;
    logic wr_en;
    logic hit;
    logic [31:0] rd_mux;

    // Lock indicator from the converter, pin domain
    acr_sync3 u_lock_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(src_locked_pin),
        .q(locked)
    );

    // Access phase seen, answered one cycle later
    assign access = psel & penable;
    assign wr_en = access & pready & pwrite & hit;

    // APB ready: one wait state, then a single-cycle answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= access & ~pready;
        end
    end

    // Address decode
    always_comb begin
        case (paddr)
            A_CONV, A_ADC, A_PWR, A_U2: hit = 1'b1;
            A_CS, A_DA, A_IST, A_IMK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Read data assembly, reserved bits read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            A_CONV: begin
                rd_mux[6:0] = conv_port_r;
            end
            A_ADC: begin
                rd_mux[3:0] = adc_sel_r;
            end
            A_PWR: begin
                rd_mux[15:0] = power_r;
            end
            A_U2: begin
                rd_mux[acr_pkg::U2_MUTE] = hp_mute_r;
                rd_mux[4:0] = hp_att_r;
            end
            A_CS: begin
                rd_mux[8:0] = clk_stat_r;
                rd_mux[12:9] = acr_pkg::CS_ONES;
                rd_mux[acr_pkg::CS_LOCK] = locked;
            end
            A_DA: begin
                rd_mux[acr_pkg::DA_CHOP_DIS] = dac_chop_dis_r;
            end
            A_IST: begin
                rd_mux[1:0] = irq_status;
            end
            A_IMK: begin
                rd_mux[1:0] = irq_mask_r;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data and error response, captured at the end of the wait state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~hit;
        end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Converter port register, bit 7 not stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_port_r <= acr_pkg::CONV_PORT_RST[6:0];
        end else if (wr_en && paddr == A_CONV) begin
            conv_port_r <= pwdata[6:0] & acr_pkg::CP_MASK;
        end
    end

    // Input mux register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_sel_r <= acr_pkg::ADC_SEL_RST;
        end else if (wr_en && paddr == A_ADC) begin
            adc_sel_r <= pwdata[3:0];
        end
    end

    // Power control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_r <= acr_pkg::POWER_RST;
        end else if (wr_en && paddr == A_PWR) begin
            power_r <= pwdata[15:0];
        end
    end

    // User control two: mute and attenuation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hp_mute_r <= acr_pkg::USER2_RST[acr_pkg::U2_MUTE];
            hp_att_r <= acr_pkg::USER2_RST[4:0];
        end else if (wr_en && paddr == A_U2) begin
            hp_mute_r <= pwdata[acr_pkg::U2_MUTE];
            hp_att_r <= pwdata[4:0];
        end
    end

    // Clock register; lock bit is not writable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_stat_r <= acr_pkg::CLK_STAT_RST;
        end else if (wr_en && paddr == A_CS) begin
            clk_stat_r <= pwdata[8:0];
            clk_stat_r[acr_pkg::CS_LOCK] <= 1'b0;
        end
    end

    // DAC amplifier register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_chop_dis_r <= acr_pkg::DAC_AMP_RST;
        end else if (wr_en && paddr == A_DA) begin
            dac_chop_dis_r <= pwdata[acr_pkg::DA_CHOP_DIS];
        end
    end

    // Interrupt mask register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_r <= acr_pkg::IRQ_MASK_RST;
        end else if (wr_en && paddr == A_IMK) begin
            irq_mask_r <= pwdata[1:0];
        end
    end

    // Lock edge events
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            locked_d_r <= 1'b0;
        end else begin
            locked_d_r <= locked;
        end
    end

    assign irq_event[acr_pkg::IRQ_LOCK_ON] = locked & ~locked_d_r;
    assign irq_event[acr_pkg::IRQ_LOCK_OFF] = ~locked & locked_d_r;
    assign irq_clear = (wr_en && paddr == A_IST) ? pwdata[1:0] : 2'h0;

    acr_irq #(
        .W(acr_pkg::IRQ_W)
    ) u_irq (
        .clk(clk),
        .rst_n(rst_n),
        .event_in(irq_event),
        .clear(irq_clear),
        .mask(irq_mask_r),
        .status(irq_status),
        .irq(irq)
    );

    // Converter serial input decode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_cfg <= '0;
        end else begin
            // Port select counts down from input three
            case (conv_port_r[6:5])
                2'h0: src_cfg.port_onehot <= 4'h8;
                2'h1: src_cfg.port_onehot <= 4'h4;
                2'h2: src_cfg.port_onehot <= 4'h2;
                default: src_cfg.port_onehot <= 4'h1;
            endcase
            src_cfg.left_high <= conv_port_r[acr_pkg::CP_LR_POL];
            src_cfg.data_rising <= conv_port_r[acr_pkg::CP_BCLK_POL];
            src_cfg.fmt_i2s <= 1'b0;
            src_cfg.fmt_left_just <= 1'b0;
            src_cfg.fmt_right_just <= 1'b0;
            src_cfg.rj_bits <= 5'h00;
            src_cfg.fmt_valid <= 1'b1;
            // Reserved codes flag an invalid format
            case (conv_port_r[2:0])
                acr_pkg::FMT_I2S: src_cfg.fmt_i2s <= 1'b1;
                acr_pkg::FMT_LJ: src_cfg.fmt_left_just <= 1'b1;
                acr_pkg::FMT_RJ24: begin
                    src_cfg.fmt_right_just <= 1'b1;
                    src_cfg.rj_bits <= 5'd24;
                end
                acr_pkg::FMT_RJ20: begin
                    src_cfg.fmt_right_just <= 1'b1;
                    src_cfg.rj_bits <= 5'd20;
                end
                acr_pkg::FMT_RJ18: begin
                    src_cfg.fmt_right_just <= 1'b1;
                    src_cfg.rj_bits <= 5'd18;
                end
                acr_pkg::FMT_RJ16: begin
                    src_cfg.fmt_right_just <= 1'b1;
                    src_cfg.rj_bits <= 5'd16;
                end
                default: src_cfg.fmt_valid <= 1'b0;
            endcase
        end
    end

    // Analog input mux to the ADC
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_input_one_en <= 1'b0;
            analog_input_two_en <= 1'b0;
            analog_input_three_en <= 1'b0;
            analog_input_four_en <= 1'b0;
        end else begin
            analog_input_one_en <= adc_sel_r[0];
            analog_input_two_en <= adc_sel_r[1];
            analog_input_three_en <= adc_sel_r[2];
            analog_input_four_en <= adc_sel_r[3];
        end
    end

    // Block power-up levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_up <= 16'h0000;
        end else begin
            power_up <= power_r;
        end
    end

    // Headphone mute and attenuation steps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hp_mute <= 1'b0;
            hp_atten_steps <= 5'h00;
        end else begin
            hp_mute <= hp_mute_r;
            hp_atten_steps <= hp_att_r;
        end
    end

    // Amplifier chopping, on while the disable bit is clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_chop_en <= 1'b0;
        end else begin
            dac_chop_en <= ~dac_chop_dis_r;
        end
    end

    // Master clock output pin enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            master_clock_out_pin_en <= 1'b0;
        end else begin
            master_clock_out_pin_en <= clk_stat_r[acr_pkg::CS_MCLK_EN];
        end
    end

    // Clock generation decode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_cfg <= '0;
        end else begin
            clk_cfg.src_mux_en <= clk_stat_r[acr_pkg::CS_MUX_EN];
            clk_cfg.mclk_x1024 <= (clk_stat_r[5:3] == acr_pkg::MSEL_X1024);
            clk_cfg.mclk_x128 <= clk_stat_r[5];
            clk_cfg.pll_ratio_onehot <= 4'(4'h1 << clk_stat_r[2:1]);
            clk_cfg.pll_in_use <= clk_stat_r[acr_pkg::CS_PLL_EN];
        end
    end
endmodule

// File: testbench/acr_regs_properties.sv
// Concurrent checks on the ports of the codec register bank
`timescale 1ns/1ns
module acr_regs_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [acr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire acr_pkg::acr_src_cfg_t src_cfg,
    input wire logic [15:0] power_up,
    input wire logic hp_mute,
    input wire logic [4:0] hp_atten_steps,
    input wire logic master_clock_out_pin_en,
    input wire acr_pkg::acr_clk_cfg_t clk_cfg,
    input wire logic dac_chop_en,
    input wire logic irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Completed writes, one strobe each for the converter port, power, user two, clock and DAC amplifier registers
    wire wr = psel && penable && pready && pwrite;
    wire w_cp = wr && paddr == (acr_pkg::IDX_CONV_PORT << 2);
    wire w_pw = wr && paddr == (acr_pkg::IDX_POWER << 2);
    wire w_u2 = wr && paddr == (acr_pkg::IDX_USER2 << 2);
    wire w_cs = wr && paddr == (acr_pkg::IDX_CLK_STAT << 2);
    wire w_da = wr && paddr == (acr_pkg::IDX_DAC_AMP << 2);
    // Decoded outputs follow two edges after the write
    property p_port_sel;
        w_cp |-> ##2 src_cfg.port_onehot == 4'h8 >> $past(pwdata[6:5], 2);
    endproperty
    a_port_sel: assert property (p_port_sel) else $error("port select wrong");
    property p_halves;
        w_cp |-> ##2 src_cfg.left_high == $past(pwdata[4], 2) && src_cfg.data_rising == $past(pwdata[3], 2);
    endproperty
    a_halves: assert property (p_halves) else $error("polarity wrong");
    property p_fmt;
        w_cp |-> ##2 src_cfg.fmt_valid == !($past(pwdata[2:0], 2) inside {3'h2, 3'h7});
    endproperty
    a_fmt: assert property (p_fmt) else $error("format validity wrong");
    property p_power;
        w_pw |-> ##2 power_up == $past(pwdata[15:0], 2);
    endproperty
    a_power: assert property (p_power) else $error("power bits wrong");
    property p_hp;
        w_u2 |-> ##2 hp_mute == $past(pwdata[7], 2) && hp_atten_steps == $past(pwdata[4:0], 2);
    endproperty
    a_hp: assert property (p_hp) else $error("headphone control wrong");
    property p_ones;
        pready && !pwrite && !pslverr && paddr == (acr_pkg::IDX_CLK_STAT << 2) |-> prdata[31:9] == 23'h00000f;
    endproperty
    a_ones: assert property (p_ones) else $error("status upper bits wrong");
    property p_mclk;
        w_cs |-> ##2 master_clock_out_pin_en == $past(pwdata[6], 2) && clk_cfg.mclk_x128 == $past(pwdata[5], 2)
            && clk_cfg.src_mux_en == $past(pwdata[8], 2);
    endproperty
    a_mclk: assert property (p_mclk) else $error("clock out control wrong");
    property p_pll;
        w_cs |-> ##2 clk_cfg.pll_ratio_onehot == 4'h1 << $past(pwdata[2:1], 2) && clk_cfg.pll_in_use == $past(pwdata[0], 2);
    endproperty
    a_pll: assert property (p_pll) else $error("pll control wrong");
    property p_chop;
        w_da |-> ##2 dac_chop_en == !$past(pwdata[1], 2);
    endproperty
    a_chop: assert property (p_chop) else $error("chopping control wrong");
    property p_err;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    // Main scenarios reached
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
    c_bad_fmt: cover property (w_cp ##2 !src_cfg.fmt_valid);
endmodule

bind acr_regs acr_regs_properties u_props (.*);

// File: testbench/tb_acr_regs.sv
// Self-checking bench of the codec register bank
`timescale 1ns/1ns
module tb_acr_regs;
    logic clk, rst_n, psel, penable, pwrite, src_locked_pin, e;
    logic [15:0] paddr, power_up;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, hp_mute, master_clock_out_pin_en, dac_chop_en, irq;
    logic analog_input_one_en, analog_input_two_en, analog_input_three_en, analog_input_four_en;
    logic [4:0] hp_atten_steps;
    acr_pkg::acr_src_cfg_t src_cfg;
    acr_pkg::acr_clk_cfg_t clk_cfg;
    int error_cnt = 0;
    int num_checks = 0;
    localparam logic [15:0] A_CP = acr_pkg::IDX_CONV_PORT << 2;
    localparam logic [15:0] A_AD = acr_pkg::IDX_ADC_SEL << 2;
    localparam logic [15:0] A_PW = acr_pkg::IDX_POWER << 2;
    localparam logic [15:0] A_U2 = acr_pkg::IDX_USER2 << 2;
    localparam logic [15:0] A_CS = acr_pkg::IDX_CLK_STAT << 2;
    localparam logic [15:0] A_DA = acr_pkg::IDX_DAC_AMP << 2;
    localparam logic [15:0] A_IS = acr_pkg::IDX_IRQ_STAT << 2;
    localparam logic [15:0] A_IM = acr_pkg::IDX_IRQ_MASK << 2;

    acr_regs uut (.*);

    // Clock at 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // One comparison, counted
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            $display("BAD %s exp %h got %h", n, x, g);
            error_cnt++;
        end
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("waits", 32'd2, n);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] x, input string n);
        apb(a, 1'b0, 32'h0);
        chk(n, x, q);
    endtask

    task automatic wt(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Reset values of registers and decoded outputs
    task automatic t_reset();
        rd(A_CP, 32'h0, "cp");
        rd(A_AD, 32'h1, "adc");
        rd(A_PW, 32'h0, "pwr");
        rd(A_U2, 32'h0, "u2");
        rd(A_CS, 32'h1e00, "cs");
        rd(A_DA, 32'h0, "dac");
        chk("ain", 4'h1, {analog_input_four_en, analog_input_three_en, analog_input_two_en, analog_input_one_en});
        chk("chop", 1, dac_chop_en);
        $display("t_reset done");
    endtask

    // Every port select, polarity and format code
    task automatic t_conv();
        logic [2:0] i;
        logic [31:0] d;
        logic [4:0] rj;
        for (int k = 0; k < 8; k++) begin
            i = k[2:0];
            d = {24'h0, 1'b1, i[1:0], i[0], i[1], i};
            rj = i == 3 ? 5'd24 : i == 4 ? 5'd20 : i == 5 ? 5'd18 : i == 6 ? 5'd16 : 5'd0;
            wr(A_CP, d);
            rd(A_CP, d & 32'h7f, "cp");
            chk("sel", 4'h8 >> i[1:0], src_cfg.port_onehot);
            chk("lr", i[0], src_cfg.left_high);
            chk("bclk", i[1], src_cfg.data_rising);
            chk("fmt", {i == 0, i == 1, i >= 3 && i <= 6, rj, i != 2 && i != 7}, src_cfg[8:0]);
        end
        $display("t_conv done");
    endtask

    // Mux, power, headphone and chopping registers
    task automatic t_misc();
        wr(A_AD, 32'hffff_fffa);
        rd(A_AD, 32'ha, "adc");
        chk("ain", 4'ha, {analog_input_four_en, analog_input_three_en, analog_input_two_en, analog_input_one_en});
        wr(A_PW, 32'h1_8006);
        rd(A_PW, 32'h8006, "pwr");
        chk("pwr_up", 16'h8006, power_up);
        wr(A_U2, 32'hffff_ffff);
        rd(A_U2, 32'h9f, "u2");
        chk("hp", 6'h3f, {hp_mute, hp_atten_steps});
        wr(A_DA, 32'hffff_ffff);
        rd(A_DA, 32'h2, "dac");
        chk("chop", 0, dac_chop_en);
        $display("t_misc done");
    endtask

    // Clock select codes, status bits and read-only lock bit
    task automatic t_clk();
        logic [2:0] i;
        for (int k = 0; k < 8; k++) begin
            i = k[2:0];
            wr(A_CS, {16'h0, 7'h7f, i[0], 1'b1, i[1], i, i[1:0], i[2]});
            rd(A_CS, {16'h0, 3'h0, 4'hf, i[0], 1'b0, i[1], i, i[1:0], i[2]}, "cs");
            chk("clk", {i[0], i == 1, i[2], 4'h1 << i[1:0], i[2]}, clk_cfg);
            chk("mco", i[1], master_clock_out_pin_en);
        end
        $display("t_clk done");
    endtask

    // Unmapped place inside the map gap
    task automatic t_bad();
        wr(16'h4164, 32'hffff_ffff);
        chk("err_w", 1, e);
        rd(16'h4164, 32'h0, "gap");
        chk("err_r", 1, e);
        rd(A_PW, 32'h8006, "pwr");
        $display("t_bad done");
    endtask

    // Lock events, mask and clear
    task automatic t_irq();
        src_locked_pin <= 1'b1;
        wt(10);
        rd(A_CS, 32'h1fff, "lock");
        chk("irq_on", 1, irq);
        rd(A_IS, 32'h1, "ist");
        wr(A_IM, 32'h3);
        wt(3);
        chk("irq_msk", 0, irq);
        wr(A_IS, 32'h1);
        rd(A_IS, 32'h0, "ist");
        wr(A_IM, 32'h0);
        wt(3);
        chk("irq_clr", 0, irq);
        src_locked_pin <= 1'b0;
        wt(10);
        chk("irq_off", 1, irq);
        rd(A_IS, 32'h2, "ist");
        wr(A_IS, 32'h2);
        wt(3);
        chk("irq_end", 0, irq);
        $display("t_irq done");
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        src_locked_pin = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_conv();
        t_misc();
        t_clk();
        t_bad();
        t_irq();
        wrap_up();
    end

    // Watchdog well beyond the expected run
    initial begin
        #500000;
        $display("BAD watchdog exp done got hang");
        error_cnt++;
        wrap_up();
    end
endmodule
